// ---- spfc_consts.vh ----
// Constants for the standby pin function control block.
// Assumes a 40 MHz controller clock and a 32-bit Avalon-MM register port.
`ifndef SPFC_CONSTS_VH
`define SPFC_CONSTS_VH
// ----------------------------------------
// Register word byte addresses.
// ----------------------------------------
`define SPFC_ADDR_POWER_PIN_SEL 4'h0
`define SPFC_ADDR_PIN_FUNC_SEL 4'h4
`define SPFC_ADDR_ACT_RESET_CTRL 4'h8
`define SPFC_ADDR_POWER_MODE_CTRL 4'hC
// ----------------------------------------
// Field positions.
// ----------------------------------------
`define SPFC_BIT_STBY_SRC_SEL 6
`define SPFC_BIT_BL_SUSP_SEL 5
`define SPFC_BIT_PIN_FUNC_SEL 7
`define SPFC_BIT_ACT_RST_TIMER 6
`define SPFC_BIT_ACT_RST_BL 3
`define SPFC_BIT_STBY_HOLD 4
`define SPFC_BIT_PANEL_ON 0
`define SPFC_BIT_SW_STBY 1
// ----------------------------------------
// Reset values and timing.
// ----------------------------------------
`define SPFC_RESET_BYTE 8'h00
`define SPFC_SUSP_STABLE_NS 1000
`define SPFC_CLK_NS 25
`define SPFC_SUSP_STABLE_CYC ((`SPFC_SUSP_STABLE_NS + `SPFC_CLK_NS - 1) / `SPFC_CLK_NS)
`endif

// ---- spfc_pin_sync.v ----
// Two-flop synchroniser with a rising-edge detector; rise_out is combinational from sync_reg and prev_reg.
// Assumes the input is asynchronous to mclk_in.
module spfc_pin_sync (
	input wire mclk_in,
	input wire rst_n_in,
	input wire pin_in,
	output wire level_out,
	output wire rise_out
);
	reg meta_reg;
	reg sync_reg;
	reg prev_reg;
	// Only sync_reg and prev_reg feed logic; meta_reg feeds the second flop alone.
	always @(posedge mclk_in) begin
		if (!rst_n_in) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end
	assign level_out = sync_reg;
	assign rise_out = sync_reg & ~prev_reg;
endmodule // spfc_pin_sync

// ---- spfc_standby_pins.v ----
// Power pin function selection with an Avalon-MM register slave.
// Assumes the pins are driven by system logic asynchronous to mclk_in.
// Assumes standby_timeout_in is a one-cycle enable pulse from an outer divider.
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`include "spfc_consts.vh"
module spfc_standby_pins #(
	parameter STBY_TIMER_W = 16,
	parameter SUSP_STABLE_CYC = `SPFC_SUSP_STABLE_CYC
) (
	input wire mclk_in,
	input wire rst_n_in,
	input wire [3:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	input wire [3:0] avs_byteenable_in,
	output reg [31:0] avs_readdata_out,
	output wire avs_waitrequest_out,
	input wire power_pin_a_in,
	input wire power_pin_b_in,
	input wire standby_timeout_in,
	output reg feature_video_enable_n_out,
	output reg standby_start_out,
	output reg standby_active_out,
	output reg standby_timer_reset_out,
	output reg backlight_reset_out,
	output reg backlight_off_out,
	output reg suspend_start_out,
	output reg suspend_active_out
);
	// ----------------------------------------
	// Register file.
	// ----------------------------------------
	// Each register keeps only its low byte; the upper write lanes are ignored,
	// so software may write whole words without side effects.
	reg [7:0] power_pin_select_reg;
	reg [7:0] pin_function_select_reg;
	reg [7:0] activity_reset_ctrl_reg;
	reg [7:0] power_mode_ctrl_reg;
	reg ack_reg;
	reg [31:0] rdata_next;
	wire wr_lane0;
	wire sel_act;
	wire sel_sby;
	wire sel_vid;
	wire bl_mode;
	wire panel_on;
	wire sw_stby;
	wire stby_hold;
	wire [1:0] pin_vec;
	wire [1:0] lvl_vec;
	wire [1:0] rise_vec;
	wire a_lvl;
	wire a_rise;
	wire b_lvl;
	wire b_rise;
	wire act_timer_rst;
	wire act_bl_rst;
	reg [STBY_TIMER_W-1:0] timer_reg;
	reg [15:0] stable_reg;
	reg timer_was_reset_reg;

	// One wait state: the request is answered on the second edge it is held.
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
	assign wr_lane0 = avs_write_in & ack_reg & avs_byteenable_in[0];

	// Writes land only on the acknowledging edge, so each is applied once.
	always @(posedge mclk_in) begin
		if (!rst_n_in) begin
			ack_reg <= 1'b0;
			power_pin_select_reg <= `SPFC_RESET_BYTE;
			pin_function_select_reg <= `SPFC_RESET_BYTE;
			activity_reset_ctrl_reg <= `SPFC_RESET_BYTE;
			power_mode_ctrl_reg <= `SPFC_RESET_BYTE;
			avs_readdata_out <= 32'h00000000;
		end else begin
			ack_reg <= (avs_read_in | avs_write_in) & ~ack_reg;
			if (avs_read_in & ~ack_reg)
				avs_readdata_out <= rdata_next;
			if (wr_lane0) begin
				case (avs_address_in)
					`SPFC_ADDR_POWER_PIN_SEL: power_pin_select_reg <= avs_writedata_in[7:0];
					`SPFC_ADDR_PIN_FUNC_SEL: pin_function_select_reg <= avs_writedata_in[7:0];
					`SPFC_ADDR_ACT_RESET_CTRL: activity_reset_ctrl_reg <= avs_writedata_in[7:0];
					`SPFC_ADDR_POWER_MODE_CTRL: power_mode_ctrl_reg <= avs_writedata_in[7:0];
					default: ;
				endcase
			end
		end
	end

	// Read mux; unmapped words read zero; status fields fill bits 8 to 12 of the power mode word.
	always @* begin
		rdata_next = 32'h00000000;
		case (avs_address_in)
			`SPFC_ADDR_POWER_PIN_SEL: rdata_next[7:0] = power_pin_select_reg;
			`SPFC_ADDR_PIN_FUNC_SEL: rdata_next[7:0] = pin_function_select_reg;
			`SPFC_ADDR_ACT_RESET_CTRL: rdata_next[7:0] = activity_reset_ctrl_reg;
			`SPFC_ADDR_POWER_MODE_CTRL: begin
				rdata_next[7:0] = power_mode_ctrl_reg;
				rdata_next[8] = standby_active_out;
				rdata_next[9] = suspend_active_out;
				rdata_next[10] = backlight_off_out;
				rdata_next[11] = a_lvl;
				rdata_next[12] = b_lvl;
			end
			default: rdata_next = 32'h00000000;
		endcase
	end

	// ----------------------------------------
	// Pin synchronisers.
	// ----------------------------------------
	// One synchroniser per pin: bit 0 is the multiplexed pin, bit 1 the second pin.
	// Nothing downstream sees a raw pin, so a pin that moves near the clock edge
	// is at worst seen one cycle late, never as two different levels at once.
	assign pin_vec = {power_pin_b_in, power_pin_a_in};
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_pin_sync
			spfc_pin_sync u_sync (
				.mclk_in(mclk_in),
				.rst_n_in(rst_n_in),
				.pin_in(pin_vec[g]),
				.level_out(lvl_vec[g]),
				.rise_out(rise_vec[g])
			);
		end
	endgenerate
	assign a_lvl = lvl_vec[0];
	assign a_rise = rise_vec[0];
	assign b_lvl = lvl_vec[1];
	assign b_rise = rise_vec[1];

	// ----------------------------------------
	// Pin function decode.
	// ----------------------------------------
	assign sel_vid = ~pin_function_select_reg[`SPFC_BIT_PIN_FUNC_SEL];
	assign sel_act = ~sel_vid & power_pin_select_reg[`SPFC_BIT_STBY_SRC_SEL];
	assign sel_sby = ~sel_vid & ~power_pin_select_reg[`SPFC_BIT_STBY_SRC_SEL];
	assign bl_mode = power_pin_select_reg[`SPFC_BIT_BL_SUSP_SEL];
	assign panel_on = power_mode_ctrl_reg[`SPFC_BIT_PANEL_ON];
	assign sw_stby = power_mode_ctrl_reg[`SPFC_BIT_SW_STBY];
	assign stby_hold = power_mode_ctrl_reg[`SPFC_BIT_STBY_HOLD];

	// Activity edges only count in activity-sense use; each reset has its own enable.
	// Both are single-cycle because the edge detector is.
	assign act_timer_rst = sel_act & a_rise & activity_reset_ctrl_reg[`SPFC_BIT_ACT_RST_TIMER];
	assign act_bl_rst = sel_act & a_rise & activity_reset_ctrl_reg[`SPFC_BIT_ACT_RST_BL];

	// ----------------------------------------
	// Standby timer, standby and backlight control.
	// ----------------------------------------
	// The inactivity timer counts enable pulses from the outer timebase; a
	// saturating counter keeps an idle system from wrapping back to zero.
	always @(posedge mclk_in) begin
		if (!rst_n_in) begin
			timer_reg <= {STBY_TIMER_W{1'b0}};
			timer_was_reset_reg <= 1'b0;
			standby_timer_reset_out <= 1'b0;
			backlight_reset_out <= 1'b0;
			standby_start_out <= 1'b0;
			standby_active_out <= 1'b0;
			feature_video_enable_n_out <= 1'b1;
			backlight_off_out <= 1'b0;
		end else begin
			// The video enable follows the pin only when it is selected.
			feature_video_enable_n_out <= sel_vid ? a_lvl : 1'b1;
			standby_timer_reset_out <= act_timer_rst;
			backlight_reset_out <= act_bl_rst;
			if (act_timer_rst) begin
				timer_reg <= {STBY_TIMER_W{1'b0}};
				timer_was_reset_reg <= 1'b1;
			end else if (standby_timeout_in & ~&timer_reg)
				timer_reg <= timer_reg + {{(STBY_TIMER_W-1){1'b0}}, 1'b1};
			standby_start_out <= 1'b0;
			if (!standby_active_out) begin
				// The pin only requests standby in request mode; else software.
				if ((sel_sby & a_lvl & panel_on) | sw_stby) begin
					standby_start_out <= 1'b1;
					standby_active_out <= 1'b1;
					// An activity edge in the entry cycle still counts, so it is not lost.
					timer_was_reset_reg <= act_timer_rst;
				end
			end else if (sel_sby & ~a_lvl & ~stby_hold & ~sw_stby
					& timer_was_reset_reg) begin
				standby_active_out <= 1'b0;
			end
			backlight_off_out <= bl_mode & b_lvl;
		end
	end

	// ----------------------------------------
	// Suspend request debounce.
	// ----------------------------------------
	// A short glitch restarts the count, so only a stable high starts suspend.
	always @(posedge mclk_in) begin
		if (!rst_n_in) begin
			stable_reg <= 16'h0000;
			suspend_start_out <= 1'b0;
			suspend_active_out <= 1'b0;
		end else begin
			suspend_start_out <= 1'b0;
			if (bl_mode | ~b_lvl | b_rise) begin
				stable_reg <= 16'h0000;
				suspend_active_out <= 1'b0;
			end else if (stable_reg < SUSP_STABLE_CYC[15:0]) begin
				stable_reg <= stable_reg + 16'h0001;
			end else if (!suspend_active_out) begin
				suspend_start_out <= 1'b1;
				suspend_active_out <= 1'b1;
			end
		end
	end
endmodule // spfc_standby_pins

// ---- spfc_checker.sv ----
// Port assertions for the standby pin control block.
// Assumes it is bound to the top module; one clock domain.
module spfc_checker (
	input logic mclk_in,
	input logic rst_n_in,
	input logic avs_read_in,
	input logic avs_waitrequest_out,
	input logic power_pin_a_in,
	input logic power_pin_b_in,
	input logic standby_start_out,
	input logic standby_active_out,
	input logic standby_timer_reset_out,
	input logic backlight_reset_out,
	input logic backlight_off_out,
	input logic suspend_start_out,
	input logic suspend_active_out
);
	// --------------------------------
	// Checks. Quiet pins for six edges outrun the synchroniser.
	// --------------------------------
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	a_wait_one_cycle: assert property ($rose(avs_read_in) |-> avs_waitrequest_out
		##1 !avs_waitrequest_out) else $error("read wait not one cycle");
	a_stby_start_pulse: assert property (standby_start_out |-> standby_active_out
		##1 !standby_start_out) else $error("standby start bad");
	a_timer_rst_pulse: assert property (standby_timer_reset_out
		|=> !standby_timer_reset_out) else $error("timer reset not a pulse");
	a_bl_rst_pulse: assert property (backlight_reset_out
		|=> !backlight_reset_out) else $error("backlight reset not a pulse");
	a_susp_start_pulse: assert property (suspend_start_out |-> suspend_active_out
		##1 !suspend_start_out) else $error("suspend start bad");
	a_bl_off_low: assert property (!power_pin_b_in [*6]
		|-> !backlight_off_out) else $error("backlight off without pin");
	a_susp_pin_low: assert property (!power_pin_b_in [*6]
		|-> !suspend_active_out) else $error("suspend without pin");
	a_act_quiet: assert property (!power_pin_a_in [*6]
		|-> !standby_timer_reset_out && !backlight_reset_out) else $error("reset without edge");
	cover property (standby_start_out);
	cover property (suspend_start_out);
	cover property (backlight_reset_out);
endmodule // spfc_checker

// ---- spfc_sys_model.sv ----
// System logic model driving the power pins and timer ticks.
// Assumes the bench sets the wanted pin levels.
module spfc_sys_model (
	input logic mclk_in,
	input logic a_lvl_in,
	input logic b_lvl_in,
	output logic pin_a_out = 1'b0,
	output logic pin_b_out = 1'b0,
	output logic tick_out = 1'b0
);
	// Ticks are sparse so the inactivity timer never runs out in a test.
	always @(posedge mclk_in) begin
		pin_a_out <= a_lvl_in;
		pin_b_out <= b_lvl_in;
		tick_out <= ($urandom % 8) == 0;
	end
endmodule // spfc_sys_model

// ---- tb.sv ----
// Self-checking bench for the standby pin control block.
// Assumes the checker and system model files are compiled first.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in = 0, rst_n_in = 0, avs_read_in = 0, avs_write_in = 0, a_l = 0, b_l = 0;
	logic [3:0] avs_address_in = 0, avs_byteenable_in = 4'hF;
	logic [31:0] avs_writedata_in = 0, q[$];
	logic [7:0] d;
	wire [31:0] rdata;
	wire wait_r, pa, pb, tick, fv_n, s_st, s_act, t_rst, b_rst, b_off, u_st, u_act;
	int failures = 0, cmp_count = 0, n_t = 0, n_b = 0, n_s = 0, n_u = 0, i;
	initial forever #12.5 mclk_in = ~mclk_in;
	spfc_sys_model m (.mclk_in(mclk_in), .a_lvl_in(a_l), .b_lvl_in(b_l), .pin_a_out(pa),
		.pin_b_out(pb), .tick_out(tick));
	spfc_standby_pins #(.SUSP_STABLE_CYC(4)) uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_r), .power_pin_a_in(pa),
		.power_pin_b_in(pb), .standby_timeout_in(tick), .feature_video_enable_n_out(fv_n),
		.standby_start_out(s_st), .standby_active_out(s_act), .standby_timer_reset_out(t_rst),
		.backlight_reset_out(b_rst), .backlight_off_out(b_off), .suspend_start_out(u_st),
		.suspend_active_out(u_act));
	// Monitor: counts pulses and takes the oldest read note on each accepted read.
	always @(posedge mclk_in) begin
		n_t += (t_rst === 1'b1);
		n_b += (b_rst === 1'b1);
		n_s += (s_st === 1'b1);
		n_u += (u_st === 1'b1);
		if (avs_read_in && wait_r === 1'b0) cmp(q.pop_front(), rdata);
	end
	task cmp(input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (e !== g) begin
			failures++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Holds the request until waitrequest is seen low at an edge.
	task bus(input logic w, input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk_in);
		avs_address_in <= a;
		avs_writedata_in <= {24'h000000, v};
		avs_write_in <= w;
		avs_read_in <= !w;
		@(posedge mclk_in);
		while (wait_r !== 1'b0) @(posedge mclk_in);
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask
	task pin(input logic a, input logic b, input int n);
		a_l <= a;
		b_l <= b;
		repeat (n) @(posedge mclk_in);
	endtask
	task results;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#125000;
		failures++;
		results();
	end
	initial begin
		void'($urandom(63679));
		repeat (2) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		for (i = 0; i < 16; i += 4) rd(i[3:0], 32'h0);
		rd(4'h2, 32'h0);
		d = $urandom & 8'h48;
		bus(1'b1, 4'h8, d);
		avs_byteenable_in <= 4'hE;
		bus(1'b1, 4'h8, 8'hFF);
		avs_byteenable_in <= 4'hF;
		rd(4'h8, {24'h0, d});
		bus(1'b1, 4'h2, 8'hFF);
		rd(4'h2, 32'h0);
		$display("test registers done");
		bus(1'b1, 4'hC, 8'h01);
		pin(1, 0, 10);
		cmp(1, fv_n);
		rd(4'hC, 32'h0801);
		pin(0, 0, 8);
		cmp(0, fv_n);
		$display("test video enable done");
		bus(1'b1, 4'h4, 8'h80);
		bus(1'b1, 4'h0, 8'h40);
		for (i = 0; i < 4; i++) begin
			d = (i[0] ? 8'h40 : 8'h00) | (i[1] ? 8'h08 : 8'h00);
			bus(1'b1, 4'h8, d);
			n_t = 0;
			n_b = 0;
			pin(1, 0, 8);
			pin(0, 0, 8);
			cmp(d[6], n_t);
			cmp(d[3], n_b);
		end
		$display("test activity done");
		bus(1'b1, 4'h0, 8'h00);
		n_s = 0;
		pin(1, 0, 10);
		cmp(1, n_s);
		rd(4'hC, 32'h0901);
		pin(0, 0, 8);
		rd(4'hC, 32'h0101);
		// Hold set: the activity edge resets the timer, yet standby must stay.
		bus(1'b1, 4'hC, 8'h11);
		bus(1'b1, 4'h0, 8'h40);
		pin(1, 0, 8);
		pin(0, 0, 10);
		// Exit is only taken from request use, so switch back before looking.
		bus(1'b1, 4'h0, 8'h00);
		rd(4'hC, 32'h0111);
		bus(1'b1, 4'hC, 8'h01);
		rd(4'hC, 32'h0001);
		// Video enable use: the software bit alone enters standby.
		bus(1'b1, 4'h4, 8'h00);
		n_s = 0;
		bus(1'b1, 4'hC, 8'h03);
		rd(4'hC, 32'h0103);
		cmp(1, n_s);
		$display("test standby done");
		bus(1'b1, 4'h0, 8'h20);
		pin(0, 1, 10);
		cmp(1, b_off);
		cmp(0, u_act);
		pin(0, 0, 8);
		bus(1'b1, 4'h0, 8'h00);
		n_u = 0;
		pin(0, 1, 2);
		pin(0, 0, 8);
		cmp(0, n_u);
		pin(0, 1, 14);
		cmp(1, n_u);
		cmp(0, b_off);
		pin(0, 0, 10);
		cmp(0, u_act);
		$display("test second pin done");
		results();
	end
endmodule // tb
bind spfc_standby_pins spfc_checker chk (.*);
